// File: hw/tcr_regs.sv
// Transmit control and hardware configuration registers behind the host strobe bus.
// Assumes the transmitter reports halt and status-full on mclk; host pins are asynchronous.
module tcr_regs (
	input  wire logic                  mclk,
	input  wire logic                  rst_b,
	input  wire logic                  host_cs_b,
	input  wire logic                  host_rd_b,
	input  wire logic                  host_wr_b,
	input  wire logic [7:0]            host_addr,
	input  wire logic [31:0]           host_data_in,
	output logic      [31:0]           host_data_out,
	output logic                       host_data_oe,
	input  wire logic                  bus_width_strap,
	input  wire logic                  wake_event,
	input  wire logic                  tx_halted,
	input  wire logic                  tx_status_full,
	input  wire logic                  phy_clocks_ok,
	output tcr_pkg::tcr_tx_ctl_t       tx_ctl,
	output logic                       tx_status_full_int,
	output logic [14:0]                tx_data_bytes,
	output logic [15:0]                rx_total_bytes,
	output logic                       mac_soft_reset,
	output logic                       tx_rx_error_flags_clr
);

	// Three-stage pin synchroniser; a level is accepted when stages two and three agree.
	tcr_pkg::tcr_pins_t pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, pin_prev_r;
	tcr_pkg::tcr_pins_t pin_now;

	assign pin_now = '{cs_b: host_cs_b, rd_b: host_rd_b, wr_b: host_wr_b,
		strap: bus_width_strap, addr: host_addr, wdata: host_data_in};

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_r <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, default: '0};
			pin_s2_r <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, default: '0};
			pin_s3_r <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, default: '0};
		end else begin
			pin_s1_r <= pin_now;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	// Filtered copy and its previous value for strobe edge detection.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_f_r    <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, default: '0};
			pin_prev_r <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, default: '0};
		end else begin
			if (pin_s2_r == pin_s3_r) begin
				pin_f_r <= pin_s3_r;
			end
			pin_prev_r <= pin_f_r;
		end
	end

	// Strobe decode: an access starts on the first filtered cycle with chip select and strobe low.
	wire rd_act   = !pin_f_r.cs_b && !pin_f_r.rd_b;
	wire wr_act   = !pin_f_r.cs_b && !pin_f_r.wr_b;
	wire rd_start = rd_act && !(!pin_prev_r.cs_b && !pin_prev_r.rd_b);
	wire wr_start = wr_act && !(!pin_prev_r.cs_b && !pin_prev_r.wr_b);
	wire sel_txc  = pin_f_r.addr == tcr_pkg::TX_CTRL_OFS;
	wire sel_hwc  = pin_f_r.addr == tcr_pkg::HWCONF_OFS;
	wire [31:0] wd = pin_f_r.wdata;

	// Register state.
	logic       unlock_r;
	logic       allow_r;
	logic       tx_on_r;
	logic       stop_r;
	logic       mbo_r;
	logic [3:0] alloc_r;
	logic       soft_reset_timeout_flag_r;
	logic       soft_reset_request_busy_r;
	tcr_pkg::tcr_soft_reset_request_t sr_state_r, sr_nxt;
	logic [7:0] sr_cnt_r;

	// A write is honoured only once a read has unlocked the bus.
	wire wr_ok    = wr_start && unlock_r;
	wire wr_txc   = wr_ok && sel_txc;
	wire wr_hwc   = wr_ok && sel_hwc;
	wire soft_reset_request_go  = wr_hwc && wd[tcr_pkg::SOFT_RESET_REQUEST_BIT] && (sr_state_r == tcr_pkg::SR_IDLE);
	wire soft_reset_request_ok  = (sr_state_r == tcr_pkg::SR_WAIT) && phy_clocks_ok;
	wire soft_reset_request_tmo = (sr_state_r == tcr_pkg::SR_WAIT) && !phy_clocks_ok
		&& (sr_cnt_r == tcr_pkg::SOFT_RESET_TIMEOUT_FLAG_CNT - 8'h01);
	wire halt_done = stop_r && tx_halted;
	wire stop_set  = wr_txc && wd[tcr_pkg::TX_STOP_BIT] && !stop_r;

	// Unlock: cleared by power-on, soft reset or a wake from power saving, set by any read.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			unlock_r <= 1'b0;
		end else if (rd_start) begin
			unlock_r <= 1'b1;
		end else if (soft_reset_request_ok || wake_event) begin
			unlock_r <= 1'b0;
		end
	end

	// Transmit control. A software set of enable wins over the automatic clear in the same cycle.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			allow_r <= 1'b0;
			tx_on_r <= 1'b0;
			stop_r  <= 1'b0;
		end else if (soft_reset_request_ok) begin
			allow_r <= 1'b0;
			tx_on_r <= 1'b0;
			stop_r  <= 1'b0;
		end else begin
			if (wr_txc) begin
				allow_r <= wd[tcr_pkg::OVR_ALLOW_BIT];
			end
			if (wr_txc) begin
				tx_on_r <= wd[tcr_pkg::TX_ENABLE_BIT];
			end else if (halt_done) begin
				tx_on_r <= 1'b0;
			end
			if (stop_set) begin
				stop_r <= 1'b1;
			end else if (halt_done) begin
				stop_r <= 1'b0;
			end
		end
	end

	// Hardware configuration; these bits survive soft reset so the FIFO split stays put.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mbo_r   <= 1'b0;
			alloc_r <= tcr_pkg::ALLOC_RST;
		end else if (wr_hwc) begin
			mbo_r   <= wd[tcr_pkg::MBO_BIT];
			alloc_r <= wd[tcr_pkg::ALLOC_LSB +: 4];
		end
	end

	// Soft reset sequencer: waits for the PHY clocks, gives up after the timeout.
	always_comb begin
		sr_nxt = sr_state_r;
		case (sr_state_r)
			tcr_pkg::SR_IDLE: begin
				if (soft_reset_request_go) begin
					sr_nxt = tcr_pkg::SR_WAIT;
				end
			end
			tcr_pkg::SR_WAIT: begin
				if (soft_reset_request_ok || soft_reset_request_tmo) begin
					sr_nxt = tcr_pkg::SR_IDLE;
				end
			end
			default: begin
				sr_nxt = tcr_pkg::SR_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sr_state_r  <= tcr_pkg::SR_IDLE;
			sr_cnt_r    <= 8'h00;
			soft_reset_timeout_flag_r   <= 1'b0;
			soft_reset_request_busy_r <= 1'b0;
		end else begin
			sr_state_r  <= sr_nxt;
			sr_cnt_r    <= (sr_state_r == tcr_pkg::SR_WAIT) ? sr_cnt_r + 8'h01 : 8'h00;
			soft_reset_request_busy_r <= (sr_nxt == tcr_pkg::SR_WAIT);
			if (soft_reset_request_tmo) begin
				soft_reset_timeout_flag_r <= 1'b1;
			end else if (soft_reset_request_go || soft_reset_request_ok) begin
				soft_reset_timeout_flag_r <= 1'b0;
			end
		end
	end

	// The allocation is clamped at the 2KB floor so a reserved code cannot underflow the split.
	wire [3:0]  alloc_eff = (alloc_r < tcr_pkg::ALLOC_MIN) ? tcr_pkg::ALLOC_MIN : alloc_r;
	wire [14:0] tx_tot    = 15'(alloc_eff) * tcr_pkg::KBYTE;
	wire [14:0] txd_calc  = tx_tot - tcr_pkg::TXS_BYTES;
	wire [15:0] rx_calc   = tcr_pkg::BUF_BYTES - {1'b0, tx_tot};
	// Full status FIFO stalls transmission unless overrun is allowed.
	wire        run_calc  = tx_on_r && !(tx_status_full && !allow_r);

	// Read data; reserved positions stay zero.
	// Both flush bits self-clear, so they always read back as zero.
	wire [31:0] rd_txc = {16'h0000, 1'b0, 1'b0, 11'h000,
		allow_r, tx_on_r, stop_r};
	wire [31:0] rd_hwc = {11'h000, mbo_r, alloc_r, 13'h0000,
		pin_f_r.strap, soft_reset_timeout_flag_r, soft_reset_request_busy_r};
	wire [31:0] rd_mux = sel_txc ? rd_txc : (sel_hwc ? rd_hwc : 32'h0000_0000);

	// Host data drive: captured at read start, held while the strobe stays active.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			host_data_out <= 32'h0000_0000;
			host_data_oe  <= 1'b0;
		end else begin
			host_data_oe <= rd_act;
			if (rd_start) begin
				host_data_out <= rd_mux;
			end
		end
	end

	// Transmitter controls and derived sizes, all registered outputs.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_ctl                <= '0;
			tx_status_full_int    <= 1'b0;
			tx_data_bytes         <= 15'h0000;
			rx_total_bytes        <= 16'h0000;
			mac_soft_reset        <= 1'b0;
			tx_rx_error_flags_clr <= 1'b0;
		end else begin
			tx_ctl.run          <= run_calc;
			tx_ctl.stop_req     <= stop_r;
			tx_ctl.status_flush <= wr_txc && wd[tcr_pkg::TXS_FLUSH_BIT];
			tx_ctl.data_flush   <= wr_txc && wd[tcr_pkg::TXD_FLUSH_BIT];
			tx_status_full_int  <= tx_status_full;
			tx_data_bytes       <= txd_calc;
			rx_total_bytes      <= rx_calc;
			mac_soft_reset        <= soft_reset_request_ok;
			tx_rx_error_flags_clr <= soft_reset_request_ok;
		end
	end

	// Checks on the behaviour above.
	a_status_flush: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_txc && wd[tcr_pkg::TXS_FLUSH_BIT] |=> tx_ctl.status_flush ##1 !tx_ctl.status_flush)
		else $error("status flush pulse wrong");
	a_data_flush: assert property (@(posedge mclk) disable iff (!rst_b)
		tx_ctl.data_flush |-> $past(wr_txc) && !$past(wd[tcr_pkg::TXD_FLUSH_BIT] == 1'b0))
		else $error("data flush without write");
	a_overrun_stall: assert property (@(posedge mclk) disable iff (!rst_b)
		tx_status_full && !allow_r |=> !tx_ctl.run)
		else $error("transmitter ran on full status FIFO");
	a_full_int: assert property (@(posedge mclk) disable iff (!rst_b)
		tx_status_full |=> tx_status_full_int)
		else $error("status full interrupt missing");
	a_enable_clear: assert property (@(posedge mclk) disable iff (!rst_b)
		halt_done && !wr_txc && !soft_reset_request_ok |=> !tx_on_r && !stop_r)
		else $error("enable or stop not cleared on halt");
	a_stop_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		stop_r && !tx_halted && !soft_reset_request_ok |=> stop_r)
		else $error("stop dropped before halt");
	a_soft_reset_request_timeout: assert property (@(posedge mclk) disable iff (!rst_b)
		soft_reset_request_go ##1 (!phy_clocks_ok) [*8] |-> ##[1:300] soft_reset_timeout_flag_r || phy_clocks_ok)
		else $error("soft reset timeout not flagged");
	a_soft_reset_request_clear: assert property (@(posedge mclk) disable iff (!rst_b)
		soft_reset_request_ok |=> mac_soft_reset && tx_rx_error_flags_clr && !tx_on_r)
		else $error("soft reset effects missing");
	a_write_lock: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_start && !unlock_r && !soft_reset_request_ok |=> $stable(alloc_r) && $stable(mbo_r)
		&& $stable(allow_r) && ($stable(tx_on_r) || $past(halt_done)))
		else $error("write accepted before first read");
	a_alloc_split: assert property (@(posedge mclk) disable iff (!rst_b)
		{1'b0, tx_data_bytes} + rx_total_bytes + 16'h0200 == tcr_pkg::BUF_BYTES
		|| $changed(alloc_r) || $past(alloc_r) != alloc_r || tx_data_bytes == 15'h0000)
		else $error("FIFO split does not sum to buffer");

endmodule

// File: hw/tcr_pkg.sv
// Constants and carrier types for the transmit control and hardware configuration registers.
// Assumes a single 20 MHz clock and a host on an asynchronous SRAM-like strobe bus.
// What this block does
// - TX status flush empties status FIFO, self-clears
// - TX data flush empties data FIFO, self-clears
// - Full status FIFO stalls transmitter unless allowed
// - Status-full interrupt ignores the overrun allowance
// - Transmit enable runs transmitter on queued data
// - Transmit enable clears after requested stop halts
// - Stop finishes current frame, then self-clears
// - Writes to stop ignored while it reads high
// - TX allocation field in 1KB units, reset 5
// - TX status takes 512 bytes, minimum 2KB
// - RX gets 16KB minus the TX allocation
// - TX data area shares commands and payload
// - Bus-width bit reflects the bus-width strap
// - Soft reset without PHY clocks times out, flags
// - Soft reset clears TX control and error flags
// - Writes ignored until first read after reset
package tcr_pkg;

	localparam logic [7:0]  TX_CTRL_OFS    = 8'h70;
	localparam logic [7:0]  HWCONF_OFS     = 8'h74;
	localparam int          TXS_FLUSH_BIT  = 15;
	localparam int          TXD_FLUSH_BIT  = 14;
	localparam int          OVR_ALLOW_BIT  = 2;
	localparam int          TX_ENABLE_BIT  = 1;
	localparam int          TX_STOP_BIT    = 0;
	localparam int          MBO_BIT        = 20;
	localparam int          ALLOC_LSB      = 16;
	localparam int          WIDTH_BIT      = 2;
	localparam int          SOFT_RESET_TIMEOUT_FLAG_BIT    = 1;
	localparam int          SOFT_RESET_REQUEST_BIT       = 0;
	localparam logic [3:0]  ALLOC_RST      = 4'h5;
	localparam logic [3:0]  ALLOC_MIN      = 4'h2;
	localparam logic [14:0] KBYTE          = 15'h0400;
	localparam logic [14:0] TXS_BYTES      = 15'h0200;
	localparam logic [15:0] BUF_BYTES      = 16'h4000;
	localparam int          MCLK_KHZ       = 20000;
	localparam int          SOFT_RESET_TIMEOUT_FLAG_US     = 10;
	localparam int          SOFT_RESET_TIMEOUT_FLAG_CYC    = SOFT_RESET_TIMEOUT_FLAG_US * MCLK_KHZ / 1000;
	localparam logic [7:0]  SOFT_RESET_TIMEOUT_FLAG_CNT    = 8'(SOFT_RESET_TIMEOUT_FLAG_CYC);

	// Host pins as one bundle so the synchroniser treats them alike.
	typedef struct packed {
		logic        cs_b;
		logic        rd_b;
		logic        wr_b;
		logic        strap;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} tcr_pins_t;

	// Controls handed to the transmitter.
	typedef struct packed {
		logic run;
		logic stop_req;
		logic status_flush;
		logic data_flush;
	} tcr_tx_ctl_t;

	typedef enum logic [1:0] {
		SR_IDLE = 2'b01,
		SR_WAIT = 2'b10
	} tcr_soft_reset_request_t;

endpackage

// File: verif/tcr_host_model.sv
// Host processor model for the asynchronous strobe bus of the register block.
// Assumes the bench calls rd and wr one at a time, each just after a clock edge.
module tcr_host_model (
	input  wire logic        mclk,
	input  wire logic        data_oe,
	output logic             cs_b,
	output logic             rd_b,
	output logic             wr_b,
	output logic [7:0]       addr,
	output logic [31:0]      wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle strobes are high; released lines show the inverse so no stale value looks valid.
	initial begin
		{cs_b, rd_b, wr_b} = 3'h7;
		addr = 8'h00;
		wdata = 32'h0000_0000;
	end

	// Read: hold the strobe until the enable is sampled high, then keep a wide gap.
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		addr = a;
		{cs_b, rd_b} = 2'h0;
		while (data_oe !== 1'b1 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
		end
		{cs_b, rd_b} = 2'h3;
		addr = ~a;
		repeat (8) @(posedge mclk);
		#1;
	endtask

	// Write: no answer exists, so the strobe stands for well over the capture delay.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr = a;
		wdata = d;
		{cs_b, wr_b} = 2'h0;
		repeat (8) @(posedge mclk);
		#1;
		{cs_b, wr_b} = 2'h3;
		addr = ~a;
		wdata = ~d;
		repeat (8) @(posedge mclk);
		#1;
	endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the transmit control and hardware configuration registers.
// Assumes the host model in its own file and the register package compiled first.
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("BAD %s exp %0h got %0h", nm, e, a); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 mclk = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 cs_b, rd_b, wr_b, oe, sint, soft_reset_request, eclr;
	logic [7:0]           addr;
	logic [31:0]          wdata, dout, w;
	logic                 strap = 1'b1, wake = 1'b0, halted = 1'b0, sfull = 1'b0, phy_ok = 1'b1;
	tcr_pkg::tcr_tx_ctl_t ctl;
	logic [14:0]          txb;
	logic [15:0]          rxb;
	logic [63:0]          q[$];
	logic [63:0]          e;
	logic [31:0]          rs = 32'h0000_0004;
	logic                 oe_q = 1'b0;
	int                   failures = 0, checks = 0, cyc = 0, n_sf = 0, n_df = 0, n_sr = 0;
	int                   n_ec = 0;

	always #25 mclk = ~mclk;

	tcr_host_model host (.mclk(mclk), .data_oe(oe), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
		.addr(addr), .wdata(wdata));

	tcr_regs uut (.mclk(mclk), .rst_b(rst_b), .host_cs_b(cs_b), .host_rd_b(rd_b),
		.host_wr_b(wr_b), .host_addr(addr), .host_data_in(wdata), .host_data_out(dout),
		.host_data_oe(oe), .bus_width_strap(strap), .wake_event(wake), .tx_halted(halted),
		.tx_status_full(sfull), .phy_clocks_ok(phy_ok), .tx_ctl(ctl),
		.tx_status_full_int(sint), .tx_data_bytes(txb), .rx_total_bytes(rxb),
		.mac_soft_reset(soft_reset_request), .tx_rx_error_flags_clr(eclr));

	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	// A read that never answered leaves its note behind, which must count as a miss.
	task automatic report_and_stop();
		`CHK("reads left", 0, q.size())
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Notes the expected word and mask, then runs the read on the bus.
	task automatic rd_exp(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m = 32'hFFFF_FFFF);
		q.push_back({m, x});
		host.rd(a);
	endtask

	// Read data is matched against the oldest note when the enable rises; pulses are counted.
	always @(posedge mclk) begin
		oe_q <= oe;
		cyc++;
		n_sf += int'(ctl.status_flush === 1'b1);
		n_df += int'(ctl.data_flush === 1'b1);
		n_sr += int'(soft_reset_request === 1'b1);
		n_ec += int'(eclr === 1'b1);
		if (soft_reset_request === 1'b1)
			`CHK("error clear", 1'b1, eclr)
		if (oe === 1'b1 && oe_q !== 1'b1) begin
			`CHK("read notes", 1, q.size())
			if (q.size() != 0) begin
				e = q.pop_front();
				`CHK("read data", e[31:0], dout & e[63:32])
			end
		end
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	// Main sequence; a write before the first read checks the lock, then the host stops the transmitter before configuring.
	initial begin
		repeat (16) @(posedge mclk);
		#1 rst_b = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		host.wr(8'h70, 32'h0000_0002);
		rd_exp(8'h70, 32'h0000_0000);
		`CHK("tx bytes", 15'h1200, txb)
		`CHK("rx bytes", 16'h2C00, rxb)
		rd_exp(8'h74, 32'h0005_0004);
		rd_exp(8'h78, 32'h0000_0000);
		host.wr(8'h70, 32'hFFFF_3FFE);
		rd_exp(8'h70, 32'h0000_0006);
		`CHK("run", 1'b1, ctl.run)
		sfull = 1'b1;
		host.wr(8'h70, 32'h0000_0002);
		`CHK("run", 1'b0, ctl.run)
		`CHK("full int", 1'b1, sint)
		host.wr(8'h70, 32'h0000_0006);
		`CHK("run", 1'b1, ctl.run)
		`CHK("full int", 1'b1, sint)
		sfull = 1'b0;
		n_sf = 0;
		n_df = 0;
		host.wr(8'h70, 32'h0000_C006);
		`CHK("status flush", 1, n_sf)
		`CHK("data flush", 1, n_df)
		`CHK("full int", 1'b0, sint)
		rd_exp(8'h70, 32'h0000_0006);
		host.wr(8'h70, 32'h0000_0003);
		`CHK("stop req", 1'b1, ctl.stop_req)
		host.wr(8'h70, 32'h0000_0002);
		rd_exp(8'h70, 32'h0000_0003);
		halted = 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		rd_exp(8'h70, 32'h0000_0000);
		`CHK("run", 1'b0, ctl.run)
		`CHK("stop req", 1'b0, ctl.stop_req)
		for (int k = 2; k <= 14; k++) begin
			strap = xs() & 1;
			w = (xs() & 32'hFFE0_FFFE) | 32'h0010_0000 | (k << 16);
			host.wr(8'h74, w);
			rd_exp(8'h74, 32'h0010_0000 | (k << 16) | (strap << 2));
			`CHK("tx bytes", 15'(k * 1024 - 512), txb)
			`CHK("rx bytes", 16'(16384 - k * 1024), rxb)
		end
		phy_ok = 1'b0;
		host.wr(8'h74, 32'h001E_0001);
		rd_exp(8'h74, 32'h001E_0001 | (strap << 2));
		repeat (210) @(posedge mclk);
		#1;
		rd_exp(8'h74, 32'h001E_0002 | (strap << 2), 32'hFFFF_FFFE);
		`CHK("soft resets", 0, n_sr)
		`CHK("error clears", 0, n_ec)
		n_sr = 0;
		n_ec = 0;
		phy_ok = 1'b1;
		host.wr(8'h74, 32'h001E_0001);
		`CHK("soft resets", 1, n_sr)
		`CHK("error clears", 1, n_ec)
		host.wr(8'h70, 32'h0000_0002);
		rd_exp(8'h70, 32'h0000_0000);
		rd_exp(8'h74, 32'h001E_0000 | (strap << 2));
		host.wr(8'h70, 32'h0000_0002);
		wake = 1'b1;
		@(posedge mclk);
		#1 wake = 1'b0;
		host.wr(8'h70, 32'h0000_0000);
		rd_exp(8'h70, 32'h0000_0002);
		report_and_stop();
	end
endmodule
